// [inc/apor_map.vh]
// register map, field positions and constants for the converter config bank
`ifndef APOR_MAP_VH
`define APOR_MAP_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define APOR_IDX_HIGH_PERF      8'h02
`define APOR_IDX_POWER_DRIVE    8'h45
`define APOR_IDX_CHB_FAST       8'h4A
`define APOR_IDX_CHA_FAST       8'h58
`define APOR_IDX_CHA_TARGET     8'hBF
`define APOR_IDX_CHB_TARGET     8'hC1
`define APOR_IDX_LOOP_CTRL      8'hCF
`define APOR_IDX_SLOW_GLOBAL    8'hEF
`define APOR_IDX_SWING_EN       8'hF1
`define APOR_IDX_CHA_SLOW       8'hF2
`define APOR_IDX_CHB_SLOW       8'hDB
`define APOR_IDX_LOOP_ENABLE    8'hE0
`define APOR_IDX_STATUS         8'hE1

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define APOR_BIT_SLEEP          7
`define APOR_BIT_CLK_DRIVE      6
`define APOR_BIT_DATA_DRIVE     5
`define APOR_BIT_POWER_OFF      2
`define APOR_BIT_FAST           0
`define APOR_TGT_HI             7
`define APOR_TGT_LO             2
`define APOR_BIT_HOLD           7
`define APOR_PER_HI             5
`define APOR_PER_LO             2
`define APOR_BIT_SLOW_GLOBAL    4
`define APOR_BIT_CHA_SLOW       3
`define APOR_BIT_CHB_SLOW       0
`define APOR_BIT_HIGH_PERF      6
`define APOR_BIT_LOOP_ENABLE    0

// ----------------------------------------------------------------------------
// values
// ----------------------------------------------------------------------------
`define APOR_RESET_VAL          8'h00
`define APOR_SWING_ON           2'h3
`define APOR_NUM_REGS           13
`define APOR_MIDCODE            14'h2000
`define APOR_ADDR_W             10
`define APOR_SAMPLE_DIV         4'h3
`define APOR_NUM_CHANS          2
`define APOR_FRAC_W             15
`define APOR_FRAC_TOP           4'hF
`define APOR_ACC_HI             28
`define APOR_ACC_LO             15

`endif

// [rtl/apor_sample_tick.v]
// divider making the sample-clock enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "apor_map.vh"

module apor_sample_tick
(
    input  wire       sys_clk,
    input  wire       rst,
    output reg        sampleTick
);

    reg  [3:0] divCount;

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            divCount   <= 4'h0;
            sampleTick <= 1'b0;
        end
        else if (divCount == `APOR_SAMPLE_DIV)
        begin
            divCount   <= 4'h0;
            sampleTick <= 1'b1;
        end
        else
        begin
            divCount   <= divCount + 4'h1;
            sampleTick <= 1'b0;
        end
    end

endmodule // apor_sample_tick
`default_nettype wire

// [rtl/apor_offset_loop.v]
// one channel's offset correction loop with pedestal and freeze
`timescale 1ns/1ps
`default_nettype none
`include "apor_map.vh"

module apor_offset_loop
(
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        sampleTick,
    input  wire        loopEnable,
    input  wire        holdEstimate,
    input  wire [3:0]  loopPeriod,
    input  wire [5:0]  offsetTarget,
    input  wire [13:0] rawSample,
    output reg  [13:0] correctedSample,
    output reg         estimateFrozen
);

    reg  [28:0] accum;
    wire [13:0] estimate;
    wire [13:0] goal;
    wire [13:0] applied;
    wire [13:0] error;
    wire [3:0]  upShift;
    wire [28:0] step;

    // integer part applied; fraction bits avoid a dead band near target
    assign estimate = accum[`APOR_ACC_HI:`APOR_ACC_LO];
    // pedestal sign-extended around midcode
    assign goal    = `APOR_MIDCODE + {{8{offsetTarget[5]}}, offsetTarget};
    assign applied = loopEnable ? rawSample - estimate : rawSample;
    assign error   = applied - goal;
    // long time constants trade settling speed for noise
    assign upShift = `APOR_FRAC_TOP - loopPeriod;
    assign step    = {{`APOR_FRAC_W{error[13]}}, error} << upShift;

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            accum           <= 29'h0000000;
            correctedSample <= 14'h0000;
            estimateFrozen  <= 1'b0;
        end
        else if (sampleTick)
        begin
            estimateFrozen  <= loopEnable & holdEstimate;
            correctedSample <= applied;
            if (!loopEnable)
            begin
                accum <= 29'h0000000;
            end
            else if (!holdEstimate)
            begin
                accum <= accum + step;
            end
        end
    end

endmodule // apor_offset_loop
`default_nettype wire

// [rtl/apor_config_bank.v]
// APB register bank for the dual-channel converter configuration
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "apor_map.vh"

module apor_config_bank
(
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [13:0] chanARaw,
    input  wire [13:0] chanBRaw,
    output reg         both_channel_sleep,
    output reg         total_power_off,
    output reg         clock_buffer_drive,
    output reg         dataBufferDrive,
    output reg         chan_a_fast_input_mode,
    output reg         chan_b_fast_input_mode,
    output reg         chan_a_slow_rate,
    output reg         chan_b_slow_rate,
    output reg         swingControlActive,
    output reg         high_performance_bit_a,
    output wire [13:0] chanACorrected,
    output wire [13:0] chanBCorrected
);

    // ------------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------------
    reg  [7:0]  regPowerDrive;
    reg  [7:0]  regChbFast;
    reg  [7:0]  regChaFast;
    reg  [7:0]  chan_a_offset_target;
    reg  [7:0]  chan_b_offset_target;
    reg  [7:0]  regLoopCtrl;
    reg  [7:0]  regSlowGlobal;
    reg  [7:0]  regSwingEn;
    reg  [7:0]  regChaSlow;
    reg  [7:0]  regChbSlow;
    reg  [7:0]  regHighPerf;
    reg  [7:0]  regLoopEnable;

    wire        sampleTick;
    wire        frozenA;
    wire        frozenB;
    wire [1:0]  chanFrozen;
    wire [5:0]  chanTarget [0:`APOR_NUM_CHANS-1];
    wire [13:0] chanRaw    [0:`APOR_NUM_CHANS-1];
    wire [13:0] chanOut    [0:`APOR_NUM_CHANS-1];
    genvar      ch;
    wire        addrOk;
    wire [7:0]  regIndex;
    wire        setup;
    wire        wrStrobe;
    reg  [7:0]  readMux;
    reg         known;

    assign setup    = psel & ~penable;
    assign addrOk   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign regIndex = paddr[9:2];
    assign wrStrobe = psel & penable & pready & pwrite & addrOk & known;

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    function isMapped;
        input [7:0] idx;
        begin
            case (idx)
                `APOR_IDX_HIGH_PERF, `APOR_IDX_POWER_DRIVE,
                `APOR_IDX_CHB_FAST, `APOR_IDX_CHA_FAST,
                `APOR_IDX_CHA_TARGET, `APOR_IDX_CHB_TARGET,
                `APOR_IDX_LOOP_CTRL, `APOR_IDX_SLOW_GLOBAL,
                `APOR_IDX_SWING_EN, `APOR_IDX_CHA_SLOW,
                `APOR_IDX_CHB_SLOW, `APOR_IDX_LOOP_ENABLE,
                `APOR_IDX_STATUS: isMapped = 1'b1;
                default: isMapped = 1'b0;
            endcase
        end
    endfunction

    always @*
    begin
        known = isMapped(regIndex);
        case (regIndex)
            `APOR_IDX_HIGH_PERF:   readMux = regHighPerf;
            `APOR_IDX_POWER_DRIVE: readMux = regPowerDrive;
            `APOR_IDX_CHB_FAST:    readMux = regChbFast;
            `APOR_IDX_CHA_FAST:    readMux = regChaFast;
            `APOR_IDX_CHA_TARGET:  readMux = chan_a_offset_target;
            `APOR_IDX_CHB_TARGET:  readMux = chan_b_offset_target;
            `APOR_IDX_LOOP_CTRL:   readMux = regLoopCtrl;
            `APOR_IDX_SLOW_GLOBAL: readMux = regSlowGlobal;
            `APOR_IDX_SWING_EN:    readMux = regSwingEn;
            `APOR_IDX_CHA_SLOW:    readMux = regChaSlow;
            `APOR_IDX_CHB_SLOW:    readMux = regChbSlow;
            `APOR_IDX_LOOP_ENABLE: readMux = regLoopEnable;
            `APOR_IDX_STATUS:      readMux = {5'h00, swingControlActive,
                                              frozenB, frozenA};
            default:               readMux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // apb slave: one wait state, answer in the second access cycle
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else if (psel & penable & ~pready)
        begin
            pready  <= 1'b1;
            pslverr <= ~(addrOk & known);
            prdata  <= (addrOk & known & ~pwrite) ?
                       {24'h000000, readMux} : 32'h00000000;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // register writes; reserved bits stored as written
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            regPowerDrive        <= `APOR_RESET_VAL;
            regChbFast           <= `APOR_RESET_VAL;
            regChaFast           <= `APOR_RESET_VAL;
            chan_a_offset_target <= `APOR_RESET_VAL;
            chan_b_offset_target <= `APOR_RESET_VAL;
            regLoopCtrl          <= `APOR_RESET_VAL;
            regSlowGlobal        <= `APOR_RESET_VAL;
            regSwingEn           <= `APOR_RESET_VAL;
            regChaSlow           <= `APOR_RESET_VAL;
            regChbSlow           <= `APOR_RESET_VAL;
            regHighPerf          <= `APOR_RESET_VAL;
            regLoopEnable        <= `APOR_RESET_VAL;
        end
        else if (wrStrobe)
        begin
            case (regIndex)
                `APOR_IDX_POWER_DRIVE: regPowerDrive <= pwdata[7:0];
                `APOR_IDX_CHB_FAST:    regChbFast    <= pwdata[7:0];
                `APOR_IDX_CHA_FAST:    regChaFast    <= pwdata[7:0];
                `APOR_IDX_CHA_TARGET:  chan_a_offset_target <= pwdata[7:0];
                `APOR_IDX_CHB_TARGET:  chan_b_offset_target <= pwdata[7:0];
                `APOR_IDX_LOOP_CTRL:   regLoopCtrl   <= pwdata[7:0];
                `APOR_IDX_SLOW_GLOBAL: regSlowGlobal <= pwdata[7:0];
                `APOR_IDX_SWING_EN:    regSwingEn    <= pwdata[7:0];
                `APOR_IDX_CHA_SLOW:    regChaSlow    <= pwdata[7:0];
                `APOR_IDX_CHB_SLOW:    regChbSlow    <= pwdata[7:0];
                `APOR_IDX_HIGH_PERF:   regHighPerf   <= pwdata[7:0];
                `APOR_IDX_LOOP_ENABLE: regLoopEnable <= pwdata[7:0];
                default:               regLoopEnable <= regLoopEnable;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // controls applied on the sample tick after the write
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            both_channel_sleep     <= 1'b0;
            total_power_off        <= 1'b0;
            clock_buffer_drive     <= 1'b0;
            dataBufferDrive        <= 1'b0;
            chan_a_fast_input_mode <= 1'b0;
            chan_b_fast_input_mode <= 1'b0;
            chan_a_slow_rate       <= 1'b0;
            chan_b_slow_rate       <= 1'b0;
            swingControlActive     <= 1'b0;
            high_performance_bit_a <= 1'b0;
        end
        else if (sampleTick)
        begin
            both_channel_sleep     <= regPowerDrive[`APOR_BIT_SLEEP];
            total_power_off        <= regPowerDrive[`APOR_BIT_POWER_OFF];
            clock_buffer_drive     <= regPowerDrive[`APOR_BIT_CLK_DRIVE];
            dataBufferDrive        <= regPowerDrive[`APOR_BIT_DATA_DRIVE];
            chan_a_fast_input_mode <= regChaFast[`APOR_BIT_FAST];
            chan_b_fast_input_mode <= regChbFast[`APOR_BIT_FAST];
            // slow bits mean nothing without the global gate
            chan_a_slow_rate <= regSlowGlobal[`APOR_BIT_SLOW_GLOBAL]
                              & regChaSlow[`APOR_BIT_CHA_SLOW];
            chan_b_slow_rate <= regSlowGlobal[`APOR_BIT_SLOW_GLOBAL]
                              & regChbSlow[`APOR_BIT_CHB_SLOW];
            // undefined codes 01 and 10 leave swing control off
            swingControlActive <= (regSwingEn[1:0] == `APOR_SWING_ON);
            high_performance_bit_a <= regHighPerf[`APOR_BIT_HIGH_PERF];
        end
    end

    // ------------------------------------------------------------------------
    // sample rate divider and per-channel loops
    // ------------------------------------------------------------------------
    apor_sample_tick u_tick
    (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .sampleTick (sampleTick)
    );

    assign chanTarget[0]  = chan_a_offset_target[`APOR_TGT_HI:`APOR_TGT_LO];
    assign chanTarget[1]  = chan_b_offset_target[`APOR_TGT_HI:`APOR_TGT_LO];
    assign chanRaw[0]     = chanARaw;
    assign chanRaw[1]     = chanBRaw;
    assign chanACorrected = chanOut[0];
    assign chanBCorrected = chanOut[1];
    assign frozenA        = chanFrozen[0];
    assign frozenB        = chanFrozen[1];

    // channels share loop controls but each keeps its own pedestal
    generate
        for (ch = 0; ch < `APOR_NUM_CHANS; ch = ch + 1)
        begin : gChan
            apor_offset_loop u_loop
            (
                .sys_clk         (sys_clk),
                .rst             (rst),
                .sampleTick      (sampleTick),
                .loopEnable      (regLoopEnable[`APOR_BIT_LOOP_ENABLE]),
                .holdEstimate    (regLoopCtrl[`APOR_BIT_HOLD]),
                .loopPeriod      (regLoopCtrl[`APOR_PER_HI:`APOR_PER_LO]),
                .offsetTarget    (chanTarget[ch]),
                .rawSample       (chanRaw[ch]),
                .correctedSample (chanOut[ch]),
                .estimateFrozen  (chanFrozen[ch])
            );
        end
    endgenerate

endmodule // apor_config_bank
`default_nettype wire

// [verif/apor_bank_asserts.sv]
// port-level checker for the config bank
`timescale 1ns/1ps
`default_nettype none
module apor_bank_asserts
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        both_channel_sleep,
    input wire logic        total_power_off,
    input wire logic        swingControlActive,
    input wire logic        chan_a_slow_rate
);
default clocking cb @(posedge sys_clk);
endclocking
default disable iff (rst);
// ----------------
// helper
// ----------------
// cycles since the last accepted write, saturating
logic [3:0] sinceWrite;
always_ff @(posedge sys_clk or posedge rst)
    if (rst)
        sinceWrite <= 4'hF;
    else if (pready && pwrite && !pslverr)
        sinceWrite <= 4'h0;
    else if (sinceWrite != 4'hF)
        sinceWrite <= sinceWrite + 4'h1;
// ----------------
// properties
// ----------------
property p_ready_wait;
    psel && penable && !pready && !$past(penable) |=> pready;
endproperty
a_ready_wait: assert property (p_ready_wait)
    else $error("pready not in second access cycle");
property p_ready_pulse;
    pready |=> !pready;
endproperty
a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
property p_ready_access;
    pready |-> psel && penable;
endproperty
a_ready_access: assert property (p_ready_access)
    else $error("pready outside access phase");
property p_err_misaligned;
    pready && paddr[1:0] != 2'h0 |-> pslverr;
endproperty
a_err_misaligned: assert property (p_err_misaligned)
    else $error("misaligned access not refused");
property p_err_data;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
endproperty
a_err_data: assert property (p_err_data)
    else $error("refused read returned data");
property p_upper_zero;
    pready && !pwrite |-> prdata[31:8] == 24'h0;
endproperty
a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits not zero");
property p_reset_zero;
    $past(rst) |-> !both_channel_sleep && !total_power_off
        && !swingControlActive && prdata == 32'h0;
endproperty
a_reset_zero: assert property (p_reset_zero)
    else $error("output not zero after reset");
property p_settle;
    $changed(both_channel_sleep) || $changed(total_power_off)
        || $changed(swingControlActive) || $changed(chan_a_slow_rate)
        |-> sinceWrite < 4'h9;
endproperty
a_settle: assert property (p_settle)
    else $error("setting changed without a recent write");
endmodule // apor_bank_asserts
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the config bank
`timescale 1ns/1ps
`default_nettype none
`include "apor_map.vh"
module tb;
logic        sys_clk = 1'b0;
logic        rst = 1'b1;
logic        psel = 1'b0;
logic        penable = 1'b0;
logic        pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0;
logic [31:0] prdata;
logic        pready;
logic        pslverr;
logic [13:0] rawA = 14'h2000;
logic [13:0] rawB = 14'h2000;
logic [13:0] corrA;
logic [13:0] corrB;
wire  [9:0]  outs;
logic [7:0]  rwIdx [0:11];
logic [31:0] rd;
logic        err;
logic [31:0] v;
integer      seed = 32'h98fc;
integer      badCount = 0;
integer      totalChecks = 0;
integer      i;
always #12.5 sys_clk = ~sys_clk;
apor_config_bank dut
(
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chanARaw(rawA), .chanBRaw(rawB),
    .both_channel_sleep(outs[9]), .total_power_off(outs[8]),
    .clock_buffer_drive(outs[7]), .dataBufferDrive(outs[6]),
    .chan_a_fast_input_mode(outs[5]), .chan_b_fast_input_mode(outs[4]),
    .chan_a_slow_rate(outs[3]), .chan_b_slow_rate(outs[2]),
    .swingControlActive(outs[1]), .high_performance_bit_a(outs[0]),
    .chanACorrected(corrA), .chanBCorrected(corrB)
);
// ----------------
// tasks
// ----------------
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
        badCount++;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic tallyAndFinish;
    if (badCount == 0 && totalChecks > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
// register value with every reserved bit cleared
function automatic logic [31:0] legalVal(input logic [7:0] idx,
                                         input logic [31:0] w);
    logic [7:0] keep;
    case (idx)
        `APOR_IDX_HIGH_PERF:   keep = 8'h40;
        `APOR_IDX_POWER_DRIVE: keep = 8'hE4;
        `APOR_IDX_CHA_TARGET,
        `APOR_IDX_CHB_TARGET:  keep = 8'hFC;
        `APOR_IDX_LOOP_CTRL:   keep = 8'hBC;
        `APOR_IDX_SLOW_GLOBAL: keep = 8'h10;
        `APOR_IDX_CHA_SLOW:    keep = 8'h08;
        default:               keep = 8'h01;
    endcase
    // swing field never gets the two forbidden codes
    if (idx == `APOR_IDX_SWING_EN)
        legalVal = {w[31:8], 6'h00, w[0], w[0]};
    else
        legalVal = {w[31:8], w[7:0] & keep};
endfunction
// expected control outputs for one stimulus word
function automatic logic [31:0] outsExp(input logic [31:0] w,
                                        input integer n);
    outsExp = {22'h0, w[7], w[2], w[6], w[5], w[8], w[9],
               w[11] & w[12], w[11] & w[13], n[0], w[10]};
endfunction
// one transfer, entered just after a rising edge
task automatic apb(input logic wr, input logic [11:0] a,
                   input logic [31:0] d);
    integer n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
        @(posedge sys_clk);
        if (pready === 1'b1)
            break;
    end
    if (n == 20)
    begin
        badCount++;
        tallyAndFinish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
endtask
task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
endtask
task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
    chk(rd, exp);
endtask
task automatic converge(input logic [13:0] ea, input logic [13:0] eb);
    integer k;
    for (k = 0; k < 400; k++)
    begin
        @(posedge sys_clk);
        if (corrA === ea && corrB === eb)
            break;
    end
    chk({corrA, corrB}, {ea, eb});
    if (k == 400)
        tallyAndFinish;
endtask
// ----------------
// sequence
// ----------------
initial
begin
    rwIdx = '{`APOR_IDX_HIGH_PERF, `APOR_IDX_POWER_DRIVE,
        `APOR_IDX_CHB_FAST, `APOR_IDX_CHA_FAST, `APOR_IDX_CHA_TARGET,
        `APOR_IDX_CHB_TARGET, `APOR_IDX_LOOP_CTRL, `APOR_IDX_SLOW_GLOBAL,
        `APOR_IDX_SWING_EN, `APOR_IDX_CHA_SLOW, `APOR_IDX_CHB_SLOW,
        `APOR_IDX_LOOP_ENABLE};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({22'h0, outs}, 32'h0);
    for (i = 0; i < 12; i++)
        rdc(rwIdx[i], 32'h0);
    rdc(`APOR_IDX_STATUS, 32'h0);
    // values with reserved bits cleared read back, upper word dropped
    for (i = 0; i < 12; i++)
    begin
        v = legalVal(rwIdx[i], $random(seed));
        wr(rwIdx[i], v);
        rdc(rwIdx[i], {24'h0, v[7:0]});
    end
    for (i = 0; i < 8; i++)
    begin
        v = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h1000 : $random(seed);
        wr(`APOR_IDX_POWER_DRIVE, {24'h0, v[7:0] & 8'hE4});
        wr(`APOR_IDX_CHA_FAST, {31'h0, v[8]});
        wr(`APOR_IDX_CHB_FAST, {31'h0, v[9]});
        wr(`APOR_IDX_HIGH_PERF, {25'h0, v[10], 6'h0});
        wr(`APOR_IDX_SLOW_GLOBAL, {27'h0, v[11], 4'h0});
        wr(`APOR_IDX_CHA_SLOW, {28'h0, v[12], 3'h0});
        wr(`APOR_IDX_CHB_SLOW, {31'h0, v[13]});
        wr(`APOR_IDX_SWING_EN, {30'h0, i[0], i[0]});
        repeat (8) @(posedge sys_clk);
        chk({22'h0, outs}, outsExp(v, i));
    end
    // refused accesses leave the bank untouched
    wr(`APOR_IDX_POWER_DRIVE, 32'h0);
    wr(`APOR_IDX_SWING_EN, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h115, 32'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'hD14, 32'hFF);
    chk({31'h0, err}, 32'h1);
    rdc(`APOR_IDX_POWER_DRIVE, 32'h0);
    // offset loop with distinct pedestals per channel
    rawA <= 14'h2155;
    rawB <= 14'h1F5D;
    wr(`APOR_IDX_CHA_TARGET, 32'h7C);
    wr(`APOR_IDX_CHB_TARGET, 32'h80);
    wr(`APOR_IDX_LOOP_CTRL, 32'h0);
    wr(`APOR_IDX_LOOP_ENABLE, 32'h1);
    converge(14'h201F, 14'h1FE0);
    wr(`APOR_IDX_LOOP_CTRL, 32'h80);
    repeat (8) @(posedge sys_clk);
    rdc(`APOR_IDX_STATUS, 32'h3);
    rawA <= 14'h2165;
    repeat (16) @(posedge sys_clk);
    chk({18'h0, corrA}, 32'h202F);
    wr(`APOR_IDX_LOOP_CTRL, 32'h0);
    converge(14'h201F, 14'h1FE0);
    wr(`APOR_IDX_CHA_TARGET, 32'h0);
    wr(`APOR_IDX_CHB_TARGET, 32'h0);
    converge(14'h2000, 14'h2000);
    // slower time constant must still settle exactly on target
    wr(`APOR_IDX_LOOP_CTRL, 32'h08);
    rawA <= 14'h2175;
    rawB <= 14'h1F4D;
    repeat (8) @(posedge sys_clk);
    converge(14'h2000, 14'h2000);
    tallyAndFinish;
end
endmodule // tb
bind apor_config_bank apor_bank_asserts u_chk
(
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .both_channel_sleep(both_channel_sleep),
    .total_power_off(total_power_off),
    .swingControlActive(swingControlActive),
    .chan_a_slow_rate(chan_a_slow_rate)
);
`default_nettype wire
